// file: rtl/tss_pkg.sv
// constants for the triac soft-start and speed-select controller
// assumes a 250 MHz logic clock and 50 Hz mains
package tss_pkg;
  localparam int CLK_KHZ = 250000;
  localparam int TICK_KHZ = 100;
  localparam int TICK_CYC = CLK_KHZ / TICK_KHZ;
  localparam int MAINS_HZ = 50;
  localparam int GATE_PULSE_US = 40;
  localparam int RETRIG_GAP_US = 20;
  localparam int PULSE_TICKS = GATE_PULSE_US * TICK_KHZ / 1000;
  localparam int GAP_TICKS = RETRIG_GAP_US * TICK_KHZ / 1000;
  localparam logic [10:0] RETRIG_MASK_CODE = 11'h00d;
  localparam logic [10:0] RETRIG_CUTOFF_TICKS = 11'(13 * 64);
  localparam logic [10:0] IGN_OFS = 11'h00a;
  localparam logic [9:0] INIT_DELAY = 10'h2b2;
  localparam int SS_TIME_MS = 2867;
  localparam int SS_SPAN = 588;
  localparam int SS_STEP_CYC = SS_TIME_MS * (CLK_KHZ / SS_SPAN);
  localparam int NO_RETRIG_PULSES = 2;
  localparam logic [3:0] IDX_MAX = 4'hf;
  localparam logic [3:0] IDX_MIN = 4'h0;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RETRIG_BIT = 1;
  typedef enum logic [1:0] {
    FIRE_WAIT = 2'b00,
    FIRE_PULSE = 2'b01,
    FIRE_GAP = 2'b10,
    FIRE_DONE = 2'b11
  } tss_fire_t;
  // ignition table, code = delay_ms * 2 * mains_hz - 10
  localparam logic [9:0] IGN_TABLE [16] = '{
    10'h244, 10'h22d, 10'h216, 10'h200, 10'h1ea, 10'h1d3, 10'h1be, 10'h1a8,
    10'h191, 10'h179, 10'h160, 10'h145, 10'h127, 10'h107, 10'h0dd, 10'h066
  };
endpackage

// file: rtl/tss_ctrl.sv
// phase-angle triac controller: mains tracking, soft start, speed select, firing
// assumes a converter delivering a 4-bit speed code and a comparator-level thermal
// input, all asynchronous to REF_CLK; registers reached over AHB-Lite
//
// Overview of operation
// - after supply settles, fire the triac and ramp to the selected speed over soft start
// - speed input at ground gives start-only mode using top table entry
// - 4-bit speed code selects one of sixteen 10-bit firing delays
// - feedback high selects 2-wire mode, input spans half reference, high voltage slow
// - feedback low selects 3-wire mode, input spans full reference
// - in 3-wire mode highest voltage is slowest, lowest voltage fastest
// - potentiometer modes finish the soft-start ramp before settling at selected speed
// - standard options: 50 Hz, retrigger on, 40 us pulses, 2867 ms soft start
// - soft start begins at 7.00 ms delay; no retrigger after 8.32 ms
// - sixteen delays fall monotonically from 5.90 ms to 1.12 ms
// - top entry 1.12 ms is full power; start-only ramp ends there
// - 100 kHz tick counter cleared each half period fires on delay match
// - with retrigger, repeat pulses 20 us after previous end until triac conducts
// - accept a new speed code only if it moves more than one step
// - over-temperature drives the motor with the first table entry
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module tss_ctrl
  import tss_pkg::*;
#(
  parameter int SS_STEP_CYCLES = SS_STEP_CYC, // logic clocks per soft-start step
  parameter int TICK_CYCLES = TICK_CYC // logic clocks per delay tick
) (
  input wire logic REF_CLK, // logic clock, 250 MHz
  input wire logic RST, // synchronous reset, active high
  input wire logic ZERO_CROSS_INPUT, // mains zero-cross comparator
  input wire logic [3:0] SPEED_CODE, // converter output for the speed input
  input wire logic MODE_FEEDBACK_PIN, // high: 2-wire, low: 3-wire
  input wire logic THERMAL_SENSE_INPUT, // high: over-temperature
  input wire logic TRIAC_ON, // high while the triac conducts
  output logic TRIAC_DRIVE_OUTPUT, // gate pulse, active high
  input wire logic HSEL, // ahb select
  input wire logic [31:0] HADDR, // ahb address
  input wire logic [1:0] HTRANS, // ahb transfer type
  input wire logic HWRITE, // ahb write
  input wire logic [2:0] HSIZE, // ahb size
  input wire logic [31:0] HWDATA, // ahb write data
  input wire logic HREADY, // ahb bus ready
  output logic HREADYOUT, // ahb slave ready
  output logic HRESP, // ahb response
  output logic [31:0] HRDATA // ahb read data
);

  function automatic logic [3:0] abs_diff(input logic [3:0] a, input logic [3:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // converter code to table index; a 2-wire divider only reaches half the reference, so the code is doubled
  function automatic logic [3:0] speed_index(input logic [3:0] code, input logic two_wire);
    logic [4:0] dbl;
    dbl = {code, 1'b0};
    if (two_wire) begin
      if (dbl > 5'h0f) begin
        speed_index = IDX_MIN;
      end else begin
        speed_index = IDX_MAX - dbl[3:0];
      end
    end else begin
      speed_index = IDX_MAX - code;
    end
  endfunction

  // input synchronisers, first stage read only by second
  localparam int SYNC_W = 8;
  logic [SYNC_W-1:0] sync_in;
  wire [SYNC_W-1:0] sync_out;
  assign sync_in = {TRIAC_ON, THERMAL_SENSE_INPUT, MODE_FEEDBACK_PIN, SPEED_CODE, ZERO_CROSS_INPUT};
  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    logic s1_r;
    logic s2_r;
    always_ff @(posedge REF_CLK) begin
      if (RST) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
      end else begin
        s1_r <= sync_in[i];
        s2_r <= s1_r;
      end
    end
    assign sync_out[i] = s2_r;
  end
  // the speed code is synchronised bit by bit, so the converter must hold it steady between updates
  logic zc_s;
  logic [3:0] code_s;
  logic fb_s;
  logic thermal_s;
  logic triac_on_s;
  assign zc_s = sync_out[0];
  assign code_s = sync_out[4:1];
  assign fb_s = sync_out[5];
  assign thermal_s = sync_out[6];
  assign triac_on_s = sync_out[7];

  // zero-cross edge marks a new half period
  logic zc_d_r;
  logic half_start;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      zc_d_r <= 1'b0;
    end else begin
      zc_d_r <= zc_s;
    end
  end
  // a reset with the pin high gives one extra half-period start, which only delays the next firing
  assign half_start = zc_s ^ zc_d_r;

  // mode is caught a few cycles after release, once the synchroniser is filled
  logic [1:0] boot_cnt_r;
  logic mode_valid_r;
  logic two_wire_r;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      boot_cnt_r <= 2'h0;
    end else if (boot_cnt_r != 2'h3) begin
      boot_cnt_r <= boot_cnt_r + 2'h1;
    end
  end

  // latched once: a thermal divider sharing the feedback pin must not flip the wiring mode later
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      mode_valid_r <= 1'b0;
      two_wire_r <= 1'b0;
    end else if (!mode_valid_r && boot_cnt_r == 2'h3) begin
      mode_valid_r <= 1'b1;
      two_wire_r <= fb_s;
    end
  end

  // control register; clearing enable stops firing but the ramp keeps running
  logic [1:0] ctrl_r;
  logic enable;
  logic retrig_en;
  assign enable = ctrl_r[CTRL_EN_BIT];
  assign retrig_en = ctrl_r[CTRL_RETRIG_BIT];

  // 100 kHz delay tick, realigned at every half period
  logic [11:0] div_r;
  logic tick;
  assign tick = (div_r == 12'(TICK_CYCLES - 1));
  always_ff @(posedge REF_CLK) begin
    if (RST || half_start || tick) begin
      div_r <= 12'h000;
    end else begin
      div_r <= div_r + 12'h001;
    end
  end

  logic [10:0] dcnt_r;
  // holds at full scale so a missing mains edge cannot wrap round into a second firing
  always_ff @(posedge REF_CLK) begin
    if (RST || half_start) begin
      dcnt_r <= 11'h000;
    end else if (tick && dcnt_r != 11'h7ff) begin
      dcnt_r <= dcnt_r + 11'h001;
    end
  end

  // speed index from the converter code
  logic [3:0] idx_raw;
  assign idx_raw = speed_index(code_s, two_wire_r);

  logic [3:0] idx_r;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      idx_r <= IDX_MAX;
    end else if (code_s == 4'h0) begin
      idx_r <= IDX_MAX;
    end else if (abs_diff(idx_raw, idx_r) > 4'h1) begin
      idx_r <= idx_raw;
    end
  end

  logic [3:0] sel_idx;
  logic [9:0] target;
  assign sel_idx = thermal_s ? IDX_MIN : idx_r;
  assign target = IGN_TABLE[sel_idx];

  // soft start ramp toward the selected delay
  logic [31:0] step_cnt_r;
  logic step;
  logic [9:0] firing_delay_target_r;
  logic ss_done_r;
  assign step = (step_cnt_r == 32'(SS_STEP_CYCLES - 1));
  always_ff @(posedge REF_CLK) begin
    if (RST || !mode_valid_r || step) begin
      step_cnt_r <= 32'h0;
    end else begin
      step_cnt_r <= step_cnt_r + 32'h1;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST || !mode_valid_r) begin
      firing_delay_target_r <= INIT_DELAY;
    end else if (step) begin
      // a potentiometer move is also ramped, never jumped
      if (firing_delay_target_r > target) begin
        firing_delay_target_r <= firing_delay_target_r - 10'h001;
      end else if (firing_delay_target_r < target) begin
        firing_delay_target_r <= firing_delay_target_r + 10'h001;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || !mode_valid_r) begin
      ss_done_r <= 1'b0;
    end else if (step && firing_delay_target_r == target) begin
      ss_done_r <= 1'b1;
    end
  end

  // firing sequencer
  tss_fire_t fire_r;
  logic [2:0] wcnt_r;
  logic [1:0] npulse_r;
  logic drive_r;
  logic match;
  logic retrig_ok;
  assign match = tick && (dcnt_r == {1'b0, firing_delay_target_r} + IGN_OFS);
  assign retrig_ok = dcnt_r < RETRIG_CUTOFF_TICKS;
  logic more_pulses;
  // without retriggering exactly two pulses go out; with it the mask zone near the half-period end stops them
  assign more_pulses = retrig_en ? retrig_ok : (npulse_r < 2'(NO_RETRIG_PULSES));
  always_ff @(posedge REF_CLK) begin
    if (RST || half_start || !enable || !mode_valid_r) begin
      fire_r <= FIRE_WAIT;
      wcnt_r <= 3'h0;
      npulse_r <= 2'h0;
      drive_r <= 1'b0;
    end else begin
      case (fire_r)
        FIRE_WAIT: begin
          if (match) begin
            fire_r <= FIRE_PULSE;
            drive_r <= 1'b1;
            wcnt_r <= 3'h0;
          end
        end
        FIRE_PULSE: begin
          if (tick) begin
            if (wcnt_r == 3'(PULSE_TICKS - 1)) begin
              fire_r <= FIRE_GAP;
              drive_r <= 1'b0;
              wcnt_r <= 3'h0;
              npulse_r <= npulse_r + 2'h1;
            end else begin
              wcnt_r <= wcnt_r + 3'h1;
            end
          end
        end
        FIRE_GAP: begin
          // triac already conducting: nothing more this half period
          if (retrig_en && triac_on_s) begin
            fire_r <= FIRE_DONE;
          end else if (tick) begin
            if (wcnt_r == 3'(GAP_TICKS - 1)) begin
              wcnt_r <= 3'h0;
              if (more_pulses) begin
                fire_r <= FIRE_PULSE;
                drive_r <= 1'b1;
              end else begin
                fire_r <= FIRE_DONE;
              end
            end else begin
              wcnt_r <= wcnt_r + 3'h1;
            end
          end
        end
        FIRE_DONE: begin
          // one firing sequence per half period; only a mains edge, a reset or clearing enable rearms
          fire_r <= FIRE_DONE;
        end
        default: begin
          fire_r <= FIRE_WAIT;
        end
      endcase
    end
  end
  assign TRIAC_DRIVE_OUTPUT = drive_r;

  // ahb-lite slave, zero wait states
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic addr_ok;
  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_r;

  // the write lands in the data phase, when HWDATA is valid
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0;
    end else begin
      wr_pend_r <= addr_ok && HWRITE;
      if (addr_ok) begin
        wr_addr_r <= HADDR;
      end
    end
  end

  logic ctrl_wr;
  assign ctrl_wr = wr_pend_r && (wr_addr_r == ADDR_CTRL);
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_r <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_r <= HWDATA[1:0];
    end
  end

  // status: delay code 22:13, selected index 12:9, flags 4:0
  logic [31:0] status_word;
  assign status_word = {9'h0, firing_delay_target_r, sel_idx, 4'h0, drive_r, thermal_s, ss_done_r, two_wire_r,
                        mode_valid_r};

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_r <= 32'h0;
    end else if (addr_ok && !HWRITE) begin
      if (HADDR == ADDR_CTRL) begin
        rdata_r <= {30'h0, ctrl_r};
      end else if (HADDR == ADDR_STATUS) begin
        rdata_r <= status_word;
      end else begin
        rdata_r <= 32'h0;
      end
    end
  end
endmodule

// file: tb/tss_mains.sv
// mains and triac stand-in: zero-cross square wave, triac latching on a gate pulse
// assumes the bench clock; half period far shorter than real mains to keep runs short
`timescale 1ns/1ps
module tss_mains #(
  parameter int HALF = 7000
) (
  input wire logic clk, // bench clock
  output logic zc, // zero-cross level
  input wire logic gate, // gate drive from the block
  output logic ton // triac conducting
);
  int n = 0;
  int np = 0;
  logic gate_d = 1'b0;
  initial begin
    zc = 1'b0;
    ton = 1'b0;
  end
  always @(posedge clk) begin
    n <= (n == HALF - 1) ? 0 : n + 1;
    gate_d <= gate;
    // load current dies at each zero crossing, so the triac drops out there
    if (n == HALF - 1) begin
      zc <= ~zc;
      ton <= 1'b0;
      np <= 0;
    end else if (gate && !gate_d) begin
      // in the low half the first pulse does not latch, so retriggering is exercised
      np <= np + 1;
      if (zc || np != 0) ton <= 1'b1;
    end
  end
endmodule

// file: tb/tss_ctrl_checker.sv
// port-level checks of the triac controller
// assumes a single REF_CLK domain with RST synchronous, active high
`timescale 1ns/1ps
module tss_ctrl_checker
  import tss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC // logic clocks per delay tick, as in the design
) (
  input wire logic REF_CLK, // clock
  input wire logic RST, // reset
  input wire logic ZERO_CROSS_INPUT, // mains edge
  input wire logic TRIAC_ON, // triac state
  input wire logic TRIAC_DRIVE_OUTPUT, // gate
  input wire logic HSEL, // ahb
  input wire logic [1:0] HTRANS, // ahb
  input wire logic HWRITE, // ahb
  input wire logic HREADY, // ahb
  input wire logic HREADYOUT, // ahb
  input wire logic HRESP, // ahb
  input wire logic [31:0] HRDATA // ahb
);
  localparam int PULSE_CYC = PULSE_TICKS * TICK_CYCLES;
  // shortest delay is 1.12 ms, i.e. 112 ticks after a mains edge
  localparam int FIRST_CYC = 112 * TICK_CYCLES;
  logic [23:0] hi_r;
  logic [23:0] age_r;
  logic rd_take;
  assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;
  always_ff @(posedge REF_CLK) begin
    hi_r <= (RST || !TRIAC_DRIVE_OUTPUT) ? 24'h0 : hi_r + 24'h1;
  end
  always_ff @(posedge REF_CLK) begin
    age_r <= (RST || $changed(ZERO_CROSS_INPUT)) ? 24'h0 : age_r + 24'h1;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence zc_edge; $changed(ZERO_CROSS_INPUT); endsequence
  sequence quiet8; !TRIAC_DRIVE_OUTPUT [*8]; endsequence
  reset_quiet_a: assert property (disable iff (1'b0) RST |=> !TRIAC_DRIVE_OUTPUT && HRDATA == 32'h0)
    else $error("drive or read data not cleared by reset");
  resp_ready_a: assert property (HREADYOUT && !HRESP) else $error("bus answer not ready or not okay");
  pulse_len_a: assert property (hi_r <= PULSE_CYC)
    else $error("gate pulse too long");
  pulse_full_a: assert property ($fell(TRIAC_DRIVE_OUTPUT) && age_r > 8 |-> hi_r == PULSE_CYC)
    else $error("gate pulse width wrong");
  retrig_gap_a: assert property ($fell(TRIAC_DRIVE_OUTPUT) && age_r > 8 |-> quiet8)
    else $error("no gap after gate pulse");
  zc_abort_a: assert property (zc_edge |-> ##5 quiet8)
    else $error("gate active after mains edge");
  first_fire_a: assert property ($rose(TRIAC_DRIVE_OUTPUT) |-> age_r >= FIRST_CYC)
    else $error("gate fired before shortest delay");
  retrig_stop_a: assert property ($rose(TRIAC_DRIVE_OUTPUT) |-> !$past(TRIAC_ON, 6))
    else $error("gate fired while triac conducting");
  rdata_hold_a: assert property (!$past(rd_take) |-> $stable(HRDATA))
    else $error("read data changed without a read");
endmodule

bind tss_ctrl tss_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.REF_CLK(REF_CLK), .RST(RST),
  .ZERO_CROSS_INPUT(ZERO_CROSS_INPUT),
  .TRIAC_ON(TRIAC_ON), .TRIAC_DRIVE_OUTPUT(TRIAC_DRIVE_OUTPUT), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA));

// file: tb/test_triac_soft_start_speed_select.sv
// self-checking bench: AHB-Lite register reads against a queue of expected values
// assumes the mains model supplies zero crossings; firing itself is left to the checker
`timescale 1ns/1ps
module test_triac_soft_start_speed_select;
  import tss_pkg::*;
  `define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
  typedef struct packed {logic [31:0] v; logic [31:0] m;} tss_exp_t;
  logic clk = 0, rst = 1, fb = 0, th = 0, hsel = 0, hw = 0, pend = 0, zc, ton, trig, hro;
  logic [3:0] code = 0, c;
  logic [1:0] ht = 0;
  logic [31:0] ha = 0, hwd = 0, hrd;
  int n_errors = 0, n_tests = 0, cyc = 0, h = 15, n;
  integer seed = 32'h5a84e945;
  tss_exp_t q[$];
  always #2 clk = ~clk;
  tss_mains u_mains (.clk(clk), .zc(zc), .gate(trig), .ton(ton));
  tss_ctrl #(.SS_STEP_CYCLES(50), .TICK_CYCLES(4)) dut (.REF_CLK(clk), .RST(rst), .ZERO_CROSS_INPUT(zc), .SPEED_CODE(code),
    .MODE_FEEDBACK_PIN(fb), .THERMAL_SENSE_INPUT(th), .TRIAC_ON(ton), .TRIAC_DRIVE_OUTPUT(trig), .HSEL(hsel),
    .HADDR(ha), .HTRANS(ht), .HWRITE(hw), .HSIZE(3'h2), .HWDATA(hwd), .HREADY(hro), .HREADYOUT(hro),
    .HRESP(), .HRDATA(hrd));
  task summarize;
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wt(input int k); repeat (k) @(posedge clk); endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1; ht <= 2'b10; hw <= w; ha <= a;
    do @(posedge clk); while (!hro);
    hsel <= 0; ht <= 2'b00; hwd <= d;
    do @(posedge clk); while (!hro);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] v, input logic [31:0] m);
    q.push_back('{v, m});
    bus(0, a, 32'h0);
  endtask
  task rst8(input logic f);
    fb <= f; rst <= 1; wt(8); rst <= 0; wt(6);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin n_errors++; summarize(); end
    if (pend && hro) begin
      `CHK("hrdata", q[0].v, hrd & q[0].m)
      void'(q.pop_front());
    end
    pend <= hsel && ht[1] && hro && !hw;
  end
  initial begin
    rst8(0);
    rd(ADDR_STATUS, {9'h0, INIT_DELAY, 13'h1}, 32'h7fe003);
    rd(ADDR_CTRL, 32'h3, '1);
    bus(1, 32'h8, '1);
    bus(1, ADDR_CTRL, 32'h0);
    rd(ADDR_CTRL, 32'h0, '1);
    rd(32'h8, 32'h0, '1);
    bus(1, ADDR_CTRL, 32'h3);
    wt(30000);
    rd(ADDR_STATUS, {9'h0, IGN_TABLE[15], 4'hf, 9'h4}, 32'h7ffe04);
    repeat (12) begin
      c = 4'($random(seed));
      code <= c;
      wt(20);
      n = 15 - c;
      if (n > h + 1 || h > n + 1) h = n;
      rd(ADDR_STATUS, 32'(h) << 9, 32'h1e00);
    end
    wt(25000);
    rd(ADDR_STATUS, {IGN_TABLE[h], 4'(h), 9'h4}, 32'h7ffe04);
    th <= 1; wt(20);
    rd(ADDR_STATUS, 32'h8, 32'h1e08);
    th <= 0; code <= 3;
    rst8(1); wt(20);
    rd(ADDR_STATUS, 32'h1203, 32'h1e03);
    code <= 8; wt(20);
    rd(ADDR_STATUS, 32'h3, 32'h1e03);
    wt(2);
    summarize();
  end
endmodule
